// File: logic/event_mask_consts.svh
// offsets, field positions, reset values and timing counts of the
// event mask and line interface control registers.
// assumes a 40 mhz core clock and a paged processor port.
`ifndef EVENT_MASK_CONSTS_SVH
`define EVENT_MASK_CONSTS_SVH

// register page and word addresses on the processor port
`define REG_PAGE            3'h1
`define EVT_MASK_ADDR       5'h1e
`define LINE_CTRL_ADDR      5'h1f
`define UNMAPPED_RDATA      8'h00

// reset values
`define EVT_MASK_RESET      8'h00
`define LINE_CTRL_RESET     8'h00

// mask register field positions
`define MASK_USED_W         5
`define MASK_LOOP_BIT       4
`define MASK_ONE_SEC_BIT    3
`define MASK_FIVE_SEC_BIT   2
`define MASK_BIT_MSG_BIT    1
`define MASK_SIG_BIT        0

// line interface control field positions
`define LINE_NRZ_BIT        7
`define LINE_TXL_LSB        4
`define LINE_EQ_DIS_BIT     3
`define LINE_RES_LSB        0
`define EQ_LEVEL_IDLE       3'h0

// timing
`define CLK_KHZ             40000
`define LOOP_CODE_TIME_MS   48
`define LOOP_CODE_CYCLES    (`LOOP_CODE_TIME_MS * `CLK_KHZ)
`define SIG_DEBOUNCE_TIME_US 8
`define SIG_DEBOUNCE_CYCLES ((`SIG_DEBOUNCE_TIME_US * `CLK_KHZ + 999) / 1000)

// bit oriented message framing and acceptance
`define BOM_FLAG_BYTE       8'hff
`define BOM_HISTORY         10
`define BOM_ACCEPT          8

`endif

// File: logic/event_mask_pkg.sv
// types shared by the event mask and line interface control bank.
// assumes the constants header supplies all field positions.
package event_mask_pkg;

	// mask word, bit 7 downto 0
	typedef struct packed {
		logic [2:0] unused;
		logic       loop_code_irq_mask;
		logic       one_second_irq_mask;
		logic       five_second_irq_mask;
		logic       bit_message_irq_mask;
		logic       signaling_change_irq_mask;
	} event_mask_t;

	// line interface control word, bit 7 downto 0
	typedef struct packed {
		logic       nrz_format_select;
		logic [2:0] tx_build_out_select;
		logic       rx_equalizer_disable;
		logic [2:0] rx_equalization_level;
	} line_ctrl_t;

endpackage

// File: logic/hold_timer.sv
// counts how long a level has stood without a break and pulses once.
// assumes the level comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module hold_timer #(
	parameter int CYCLES = 16
) (
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	input  wire logic i_level,
	input  wire logic i_restart,
	output logic      o_done
);
	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] count;

	// count saturates so the pulse fires only once per stretch
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count <= '0;
		end else if (!i_level || i_restart) begin
			count <= '0;
		end else if (count != W'(CYCLES)) begin
			count <= count + 1'b1;
		end
	end

	// one pulse when the level has been seen for CYCLES samples
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_done <= 1'b0;
		end else begin
			o_done <= i_level && !i_restart && (count == W'(CYCLES - 1));
		end
	end

endmodule // hold_timer

`default_nettype wire

// File: logic/bit_message_detect.sv
// finds bit oriented messages in the data link and accepts a new one.
// assumes one data link bit per i_bit_valid, first bit first.
`timescale 1ns/10ps
`default_nettype none
`include "event_mask_consts.svh"

module bit_message_detect (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_bit,
	input  wire logic       i_bit_valid,
	output logic            o_new_message,
	output logic [5:0]      o_message
);
	logic [15:0]                     shift;
	logic [15:0]                     next_shift;
	logic                            match;
	logic [`BOM_HISTORY-1:0][5:0]    hist;
	logic [`BOM_HISTORY-1:0]         hist_valid;
	logic                            accepted_valid;
	logic [3:0]                      hits;

	// matches of code among the nine newest older positions plus the new one
	function automatic logic [3:0] count_hits(
		input logic [5:0]                  code,
		input logic [`BOM_HISTORY-1:0][5:0] h,
		input logic [`BOM_HISTORY-1:0]      v
	);
		logic [3:0] n;
		n = 4'h1;
		for (int i = 0; i < `BOM_HISTORY - 1; i++) begin
			if (v[i] && h[i] == code) begin
				n = n + 4'h1;
			end
		end
		return n;
	endfunction

	// pattern 11111111 0 xxxxxx 0 ending in the newest bit
	always_comb begin
		next_shift = {shift[14:0], i_bit};
		match = i_bit_valid && next_shift[15:8] == `BOM_FLAG_BYTE &&
			!next_shift[7] && !next_shift[0];
		hits = count_hits(next_shift[6:1], hist, hist_valid);
	end

	// clearing after a hit stops overlapping frames from matching twice
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shift <= 16'h0000;
		end else if (match) begin
			shift <= 16'h0000;
		end else if (i_bit_valid) begin
			shift <= next_shift;
		end
	end

	// ten most recent message positions
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hist       <= '0;
			hist_valid <= '0;
		end else if (match) begin
			hist       <= {hist[`BOM_HISTORY-2:0], next_shift[6:1]};
			hist_valid <= {hist_valid[`BOM_HISTORY-2:0], 1'b1};
		end
	end

	// accept only a persistent code that differs from the last one
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_new_message  <= 1'b0;
			o_message      <= 6'h00;
			accepted_valid <= 1'b0;
		end else begin
			o_new_message <= 1'b0;
			if (match && hits >= 4'(`BOM_ACCEPT) && (!accepted_valid ||
				next_shift[6:1] != o_message)) begin
				o_new_message  <= 1'b1;
				o_message      <= next_shift[6:1];
				accepted_valid <= 1'b1;
			end
		end
	end

	property p_bom_persist;
		@(posedge i_clk) disable iff (!i_rst_b)
		$rose(o_new_message) |-> $past(hits) >= 4'(`BOM_ACCEPT);
	endproperty
	a_bom_persist: assert property (p_bom_persist)
		else $error("message accepted with too few hits");

endmodule // bit_message_detect

`default_nettype wire

// File: logic/event_mask_line_config_regs.sv
// event mask word and line interface control word of a t1 framer,
// with the event detection they gate and the framer-only line format.
// assumes processor port strobes already on i_clk, one cycle wide.
`timescale 1ns/10ps
`default_nettype none
`include "event_mask_consts.svh"

module event_mask_line_config_regs #(
	parameter int LOOP_CODE_CYCLES = `LOOP_CODE_CYCLES,
	parameter int SIG_DEBOUNCE_CYCLES = `SIG_DEBOUNCE_CYCLES
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic [2:0] i_page,
	input  wire logic [4:0] i_addr,
	input  wire logic       i_reg_sel,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata,
	input  wire logic       i_loop_up_detect,
	input  wire logic       i_loop_down_detect,
	input  wire logic       i_one_second_flag,
	input  wire logic       i_five_second_flag,
	input  wire logic       i_fdl_bit,
	input  wire logic       i_fdl_bit_valid,
	input  wire logic [3:0] i_signaling_bits,
	input  wire logic       i_abcd_mode,
	input  wire logic       i_signaling_debounce_enable,
	output logic            o_irq,
	output logic      [4:0] o_irq_source,
	output logic      [5:0] o_bit_message,
	input  wire logic       i_line_if_disable,
	input  wire logic       i_rx_line_in_a,
	input  wire logic       i_rx_line_in_b,
	output logic            o_rx_nrz_data,
	output logic            o_rx_pos,
	output logic            o_rx_neg,
	input  wire logic       i_tx_nrz,
	input  wire logic       i_tx_pos,
	input  wire logic       i_tx_neg,
	output logic            o_tx_line_out_a,
	output logic            o_tx_line_out_b,
	output logic      [2:0] o_tx_build_out_select,
	output logic            o_rx_equalizer_disable,
	output logic            o_rx_eq_force,
	output logic      [2:0] o_rx_equalization_level
);
	event_mask_pkg::event_mask_t event_mask_word_three;
	event_mask_pkg::line_ctrl_t  line_interface_control;

	logic       hit_mask;
	logic       hit_line;
	logic       one_second_prev;
	logic       five_second_prev;
	logic       loop_done;
	logic       bom_new;
	logic [3:0] sig_view;
	logic [3:0] sig_prev;
	logic [3:0] sig_accepted;
	logic       sig_differs;
	logic       sig_settled;
	logic       sig_change;
	logic [4:0] event_now;
	logic [4:0] event_gated;
	logic [2:0] rx_a_sync;
	logic [2:0] rx_b_sync;
	logic       rx_a;
	logic       rx_b;

	// address decode for one word on the selected page
	function automatic logic addr_hit(
		input logic [2:0] page,
		input logic [4:0] addr,
		input logic [4:0] word
	);
		return page == `REG_PAGE && addr == word;
	endfunction

	assign hit_mask = i_reg_sel && addr_hit(i_page, i_addr, `EVT_MASK_ADDR);
	assign hit_line = i_reg_sel && addr_hit(i_page, i_addr, `LINE_CTRL_ADDR);

	// mask word; the unused top bits are never stored
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			event_mask_word_three <= `EVT_MASK_RESET;
		end else if (i_wr_en && hit_mask) begin
			event_mask_word_three <= {3'h0, i_wdata[`MASK_USED_W-1:0]};
		end
	end

	// line interface word
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			line_interface_control <= `LINE_CTRL_RESET;
		end else if (i_wr_en && hit_line) begin
			line_interface_control <= i_wdata;
		end
	end

	// read data register; other addresses answer zero
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= `UNMAPPED_RDATA;
		end else if (i_rd_en) begin
			if (hit_mask) begin
				o_rdata <= event_mask_word_three;
			end else if (hit_line) begin
				o_rdata <= line_interface_control;
			end else begin
				o_rdata <= `UNMAPPED_RDATA;
			end
		end
	end

	// loop codes are timed together: a swap between them keeps counting
	hold_timer #(
		.CYCLES (LOOP_CODE_CYCLES)
	) u_loop_timer (
		.i_clk     (i_clk),
		.i_rst_b   (i_rst_b),
		.i_level   (i_loop_up_detect || i_loop_down_detect),
		.i_restart (1'b0),
		.o_done    (loop_done)
	);

	// status flag edge history
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			one_second_prev  <= 1'b0;
			five_second_prev <= 1'b0;
		end else begin
			one_second_prev  <= i_one_second_flag;
			five_second_prev <= i_five_second_flag;
		end
	end

	bit_message_detect u_bit_message (
		.i_clk         (i_clk),
		.i_rst_b       (i_rst_b),
		.i_bit         (i_fdl_bit),
		.i_bit_valid   (i_fdl_bit_valid),
		.o_new_message (bom_new),
		.o_message     (o_bit_message)
	);

	// in ab mode the c and d positions are not compared
	assign sig_view = i_abcd_mode ? i_signaling_bits :
		{i_signaling_bits[3:2], 2'b00};
	assign sig_differs = sig_view != sig_accepted;

	// debounce restarts whenever the compared pattern moves again
	hold_timer #(
		.CYCLES (SIG_DEBOUNCE_CYCLES)
	) u_sig_debounce (
		.i_clk     (i_clk),
		.i_rst_b   (i_rst_b),
		.i_level   (sig_differs),
		.i_restart (sig_view != sig_prev),
		.o_done    (sig_settled)
	);

	assign sig_change = i_signaling_debounce_enable ? sig_settled :
		sig_differs;

	// accepted signaling state
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sig_prev     <= 4'h0;
			sig_accepted <= 4'h0;
		end else begin
			sig_prev <= sig_view;
			if (sig_change) begin
				sig_accepted <= sig_view;
			end
		end
	end

	// order matches the mask word bits 4 downto 0
	assign event_now = {
		loop_done,
		i_one_second_flag && !one_second_prev,
		i_five_second_flag && !five_second_prev,
		bom_new,
		sig_change
	};
	assign event_gated = event_now &
		event_mask_word_three[`MASK_USED_W-1:0];

	// interrupt request is a one cycle pulse per gated event
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq_source <= 5'h00;
			o_irq        <= 1'b0;
		end else begin
			o_irq_source <= event_gated;
			o_irq        <= |event_gated;
		end
	end

	// three stage pin synchronisers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_a_sync <= 3'h0;
			rx_b_sync <= 3'h0;
		end else begin
			rx_a_sync <= {rx_a_sync[1:0], i_rx_line_in_a};
			rx_b_sync <= {rx_b_sync[1:0], i_rx_line_in_b};
		end
	end

	// a level counts once the two later stages agree
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_a <= 1'b0;
			rx_b <= 1'b0;
		end else begin
			if (rx_a_sync[1] == rx_a_sync[2]) begin
				rx_a <= rx_a_sync[2];
			end
			if (rx_b_sync[1] == rx_b_sync[2]) begin
				rx_b <= rx_b_sync[2];
			end
		end
	end

	// digital line format, only meaningful with the analog front end off
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rx_nrz_data   <= 1'b0;
			o_rx_pos        <= 1'b0;
			o_rx_neg        <= 1'b0;
			o_tx_line_out_a <= 1'b0;
			o_tx_line_out_b <= 1'b0;
		end else if (!i_line_if_disable) begin
			o_rx_nrz_data   <= 1'b0;
			o_rx_pos        <= 1'b0;
			o_rx_neg        <= 1'b0;
			o_tx_line_out_a <= 1'b0;
			o_tx_line_out_b <= 1'b0;
		end else if (line_interface_control.nrz_format_select) begin
			o_rx_nrz_data   <= rx_a;
			o_rx_pos        <= 1'b0;
			o_rx_neg        <= 1'b0;
			o_tx_line_out_a <= 1'b0;
			o_tx_line_out_b <= i_tx_nrz;
		end else begin
			o_rx_nrz_data   <= 1'b0;
			o_rx_pos        <= rx_a;
			o_rx_neg        <= rx_b;
			o_tx_line_out_a <= i_tx_pos;
			o_tx_line_out_b <= i_tx_neg;
		end
	end

	// analog front end controls; any level code is passed on only while the equalizer disable bit is set
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_tx_build_out_select   <= 3'h0;
			o_rx_equalizer_disable  <= 1'b0;
			o_rx_eq_force           <= 1'b0;
			o_rx_equalization_level <= `EQ_LEVEL_IDLE;
		end else begin
			o_tx_build_out_select <=
				line_interface_control.tx_build_out_select;
			o_rx_equalizer_disable <=
				line_interface_control.rx_equalizer_disable;
			o_rx_eq_force <= line_interface_control.rx_equalizer_disable;
			o_rx_equalization_level <=
				line_interface_control.rx_equalizer_disable ?
				line_interface_control.rx_equalization_level :
				`EQ_LEVEL_IDLE;
		end
	end

	property p_one_second_irq;
		@(posedge i_clk) disable iff (!i_rst_b)
		$rose(i_one_second_flag) && event_mask_word_three[`MASK_ONE_SEC_BIT]
			|=> o_irq_source[`MASK_ONE_SEC_BIT] && o_irq;
	endproperty
	a_one_second_irq: assert property (p_one_second_irq)
		else $error("one second rise did not interrupt");

	property p_five_second_irq;
		@(posedge i_clk) disable iff (!i_rst_b)
		$rose(i_five_second_flag) && event_mask_word_three[`MASK_FIVE_SEC_BIT]
			|=> o_irq_source[`MASK_FIVE_SEC_BIT] && o_irq;
	endproperty
	a_five_second_irq: assert property (p_five_second_irq)
		else $error("five second rise did not interrupt");

	property p_mask_blocks;
		@(posedge i_clk) disable iff (!i_rst_b)
		(o_irq_source & ~$past(event_mask_word_three[4:0])) == 5'h00;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks)
		else $error("masked source raised an interrupt");

	property p_eq_ignored;
		@(posedge i_clk) disable iff (!i_rst_b)
		!o_rx_equalizer_disable |-> o_rx_equalization_level == `EQ_LEVEL_IDLE;
	endproperty
	a_eq_ignored: assert property (p_eq_ignored)
		else $error("forced level leaked with equalizer on");

	sequence s_line_write;
		i_wr_en && hit_line;
	endsequence

	sequence s_line_read;
		i_rd_en && !i_wr_en && hit_line;
	endsequence

	property p_line_readback;
		@(posedge i_clk) disable iff (!i_rst_b)
		s_line_write ##1 s_line_read |=> o_rdata == $past(i_wdata, 2);
	endproperty
	a_line_readback: assert property (p_line_readback)
		else $error("line word did not read back");

	property p_eq_disable;
		@(posedge i_clk) disable iff (!i_rst_b)
		s_line_write |-> ##2
			o_rx_equalizer_disable == $past(i_wdata[`LINE_EQ_DIS_BIT], 2);
	endproperty
	a_eq_disable: assert property (p_eq_disable)
		else $error("equalizer disable not applied");

	property p_nrz_tx;
		@(posedge i_clk) disable iff (!i_rst_b)
		i_line_if_disable && line_interface_control.nrz_format_select
			|=> o_tx_line_out_b == $past(i_tx_nrz) && !o_tx_line_out_a;
	endproperty
	a_nrz_tx: assert property (p_nrz_tx)
		else $error("nrz transmit not on line b");

	property p_dual_rail_tx;
		@(posedge i_clk) disable iff (!i_rst_b)
		i_line_if_disable && !line_interface_control.nrz_format_select
			|=> o_tx_line_out_a == $past(i_tx_pos) &&
			o_tx_line_out_b == $past(i_tx_neg);
	endproperty
	a_dual_rail_tx: assert property (p_dual_rail_tx)
		else $error("dual rail transmit wrong");

endmodule // event_mask_line_config_regs

`default_nettype wire

// File: bench/test_event_mask_line_config_regs.sv
// self-checking bench for the event mask and line interface control bank.
// assumes short loop and debounce counts, handed over as parameters.
`timescale 1ns/10ps
`default_nettype none
`include "event_mask_consts.svh"

module test_event_mask_line_config_regs;
	localparam int LOOP_N = 20;
	localparam int DEB_N  = 4;

	logic        i_clk, i_rst_b, i_reg_sel, i_wr_en, i_rd_en;
	logic [2:0]  i_page;
	logic [4:0]  i_addr;
	logic [7:0]  i_wdata, o_rdata, q, d8;
	logic        i_loop_up_detect, i_loop_down_detect, i_one_second_flag;
	logic        i_five_second_flag, i_fdl_bit, i_fdl_bit_valid, i_abcd_mode;
	logic [3:0]  i_signaling_bits;
	logic        i_signaling_debounce_enable, o_irq, i_line_if_disable;
	logic [4:0]  o_irq_source;
	logic [5:0]  o_bit_message;
	logic        i_rx_line_in_a, i_rx_line_in_b, o_rx_nrz_data, o_rx_pos;
	logic        o_rx_neg, i_tx_nrz, i_tx_pos, i_tx_neg, fo, nrz;
	logic        o_tx_line_out_a, o_tx_line_out_b, o_rx_equalizer_disable;
	logic        o_rx_eq_force;
	logic [2:0]  o_tx_build_out_select, o_rx_equalization_level;
	logic [31:0] rng, r;
	int          fails, checked, seen[5], want[5];

	event_mask_line_config_regs #(
		.LOOP_CODE_CYCLES   (LOOP_N),
		.SIG_DEBOUNCE_CYCLES(DEB_N)
	) u_event_mask_line_config_regs (
		.i_clk, .i_rst_b, .i_page, .i_addr, .i_reg_sel, .i_wr_en, .i_rd_en,
		.i_wdata, .o_rdata, .i_loop_up_detect, .i_loop_down_detect,
		.i_one_second_flag, .i_five_second_flag, .i_fdl_bit, .i_fdl_bit_valid,
		.i_signaling_bits, .i_abcd_mode, .i_signaling_debounce_enable, .o_irq,
		.o_irq_source, .o_bit_message, .i_line_if_disable, .i_rx_line_in_a,
		.i_rx_line_in_b, .o_rx_nrz_data, .o_rx_pos, .o_rx_neg, .i_tx_nrz,
		.i_tx_pos, .i_tx_neg, .o_tx_line_out_a, .o_tx_line_out_b,
		.o_tx_build_out_select, .o_rx_equalizer_disable, .o_rx_eq_force,
		.o_rx_equalization_level
	);

	// free running 40 mhz clock
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic check(input string name, input logic [31:0] got,
		input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// xorshift keeps the run repeatable from one seed
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_sel <= 1'b1;
		i_wr_en <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
		i_reg_sel <= 1'b0;
	endtask

	// read data lands one edge after the strobe and then holds
	task automatic rd(input logic [2:0] pg, input logic [4:0] a,
		output logic [7:0] d);
		@(posedge i_clk);
		i_page <= pg;
		i_addr <= a;
		i_reg_sel <= 1'b1;
		i_rd_en <= 1'b1;
		@(posedge i_clk);
		i_rd_en <= 1'b0;
		i_reg_sel <= 1'b0;
		i_page <= `REG_PAGE;
		@(posedge i_clk);
		#1 d = o_rdata;
	endtask

	// let late pulses land, then compare tallies against the model
	task automatic ev_check();
		cyc(8);
		for (int i = 0; i < 5; i++) begin
			check("irq count", seen[i], want[i]);
		end
	endtask

	// one data link frame, first bit first, a strobe every other cycle
	task automatic frame(input logic [5:0] c);
		logic [15:0] bits;
		bits = {`BOM_FLAG_BYTE, 1'b0, c, 1'b0};
		for (int j = 15; j >= 0; j--) begin
			@(posedge i_clk);
			i_fdl_bit <= bits[j];
			i_fdl_bit_valid <= 1'b1;
			@(posedge i_clk);
			i_fdl_bit_valid <= 1'b0;
		end
	endtask

	// tally interrupt pulses per source; summary must be their or
	always @(posedge i_clk) begin
		if (i_rst_b === 1'b1) begin
			for (int i = 0; i < 5; i++) begin
				if (o_irq_source[i] === 1'b1) seen[i]++;
			end
			check("irq summary", o_irq, |o_irq_source);
		end
	end

	// a hang counts against the run
	initial begin
		#2000000;
		fails++;
		summarize();
	end

	initial begin
		{i_reg_sel, i_wr_en, i_rd_en, i_addr, i_wdata} = '0;
		{i_loop_up_detect, i_loop_down_detect, i_one_second_flag} = '0;
		{i_five_second_flag, i_fdl_bit, i_fdl_bit_valid, i_abcd_mode} = '0;
		{i_signaling_bits, i_signaling_debounce_enable} = '0;
		{i_line_if_disable, i_rx_line_in_a, i_rx_line_in_b} = '0;
		{i_tx_nrz, i_tx_pos, i_tx_neg} = '0;
		i_page = `REG_PAGE;
		rng = 32'h469acdcb;
		i_rst_b = 1'b0;
		cyc(5);
		i_rst_b <= 1'b1;
		rd(3'h1, `EVT_MASK_ADDR, q);
		check("mask reset", q, `EVT_MASK_RESET);
		rd(3'h1, `LINE_CTRL_ADDR, q);
		check("line reset", q, 8'h00);
		// every build out code, both equalizer settings, random levels
		for (int i = 0; i < 8; i++) begin
			r = xs();
			d8 = {r[7], i[2:0], i[0], r[2:0]};
			wr(`LINE_CTRL_ADDR, d8);
			rd(3'h1, `LINE_CTRL_ADDR, q);
			check("line word", q, d8);
			check("build out", o_tx_build_out_select, i[2:0]);
			check("eq disable", o_rx_equalizer_disable, d8[3]);
			check("eq force", o_rx_eq_force, d8[3]);
			check("eq level", o_rx_equalization_level,
				d8[3] ? d8[2:0] : `EQ_LEVEL_IDLE);
		end
		// write then read on the very next edge, as the port allows
		@(posedge i_clk);
		i_reg_sel <= 1'b1;
		i_addr <= `LINE_CTRL_ADDR;
		i_wdata <= 8'h5b;
		i_wr_en <= 1'b1;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
		i_rd_en <= 1'b1;
		@(posedge i_clk);
		i_rd_en <= 1'b0;
		i_reg_sel <= 1'b0;
		@(posedge i_clk);
		#1 check("back to back", o_rdata, 8'h5b);
		r = xs();
		wr(`EVT_MASK_ADDR, r[7:0] | 8'he0);
		rd(3'h1, `EVT_MASK_ADDR, q);
		check("mask word", q, r[7:0] & 8'h1f);
		rd(3'h1, 5'h1d, q);
		check("unmapped word", q, `UNMAPPED_RDATA);
		rd(3'h2, `EVT_MASK_ADDR, q);
		check("other page", q, `UNMAPPED_RDATA);
		// each source but the bit message masked, then unmasked
		for (int m = 0; m < 2; m++) begin
			wr(`EVT_MASK_ADDR, m ? 8'h1f : 8'h00);
			i_signaling_debounce_enable <= 1'b0;
			i_one_second_flag <= 1'b1;
			i_five_second_flag <= 1'b1;
			cyc(3);
			i_one_second_flag <= 1'b0;
			i_five_second_flag <= 1'b0;
			want[3] += m;
			want[2] += m;
			ev_check();
			i_loop_down_detect <= 1'b1;
			cyc(LOOP_N + 10);
			i_loop_down_detect <= 1'b0;
			want[4] += m;
			cyc(2);
			// a burst shorter than the hold time must stay quiet
			i_loop_up_detect <= 1'b1;
			cyc(LOOP_N - 10);
			i_loop_up_detect <= 1'b0;
			ev_check();
			// low bits are outside the compare in ab mode
			i_signaling_bits <= i_signaling_bits ^ 4'h3;
			cyc(3);
			i_signaling_bits <= i_signaling_bits ^ 4'h8;
			want[0] += m;
			cyc(3);
			i_signaling_debounce_enable <= 1'b1;
			cyc(3);
			// a one cycle glitch is filtered when debounce is on
			i_signaling_bits <= i_signaling_bits ^ 4'h4;
			cyc(1);
			i_signaling_bits <= i_signaling_bits ^ 4'h4;
			cyc(DEB_N + 4);
			i_signaling_bits <= i_signaling_bits ^ 4'h4;
			cyc(DEB_N + 4);
			want[0] += m;
			ev_check();
		end
		wr(`EVT_MASK_ADDR, 8'h1f);
		repeat (8) frame(6'h2a);
		want[1]++;
		ev_check();
		check("message", o_bit_message, 6'h2a);
		repeat (7) frame(6'h15);
		ev_check();
		frame(6'h15);
		want[1]++;
		ev_check();
		frame(6'h15);
		ev_check();
		check("message", o_bit_message, 6'h15);
		// framer-only line formats; last two passes keep the line unit on
		for (int k = 0; k < 12; k++) begin
			r = xs();
			fo = (k < 10);
			nrz = k[0];
			wr(`LINE_CTRL_ADDR, {nrz, 7'h00});
			i_line_if_disable <= fo;
			{i_tx_neg, i_tx_pos, i_tx_nrz} <= r[4:2];
			{i_rx_line_in_b, i_rx_line_in_a} <= r[1:0];
			cyc(8);
			#1;
			if (!fo || nrz) check("rx nrz", o_rx_nrz_data, fo & r[0]);
			if (!fo || !nrz) check("rx pos", o_rx_pos, fo & r[0]);
			if (!fo || !nrz) check("rx neg", o_rx_neg, fo & r[1]);
			check("tx a", o_tx_line_out_a, fo & !nrz & r[3]);
			check("tx b", o_tx_line_out_b, fo & (nrz ? r[2] : r[4]));
		end
		summarize();
	end
endmodule // test_event_mask_line_config_regs

`default_nettype wire
